// file: bsc_defs.svh
// Constants for the bit-test, call and clear-file execution block.
// Notes on behaviour
// [RL1] Bit-test, tested bit 0: next instruction runs normally, no skip.
// [RL2] Tested bit 1: next word discarded, a no-op runs; two cycles.
// [RL3] Bit-test first cycle: decode Q1, read Q2, process Q3, no write Q4.
// [RL4] Call has top bits 100; literal loads program counter bits 10:0.
// [RL5] Call pushes program counter plus one onto the return stack first.
// [RL6] Call fills counter bits above the literal from the high latch.
// [RL7] Call is one word, two cycles; second cycle idles in every phase.
// [RL8] Clear-file writes 00h to the register in Q4 and sets zero flag only.
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH
`define BSC_IW_W 14
`define BSC_PC_W 13
`define BSC_FA_W 7
`define BSC_LIT_W 11
`define BSC_LATCH_LO 3
`define BSC_CALL_OP 3'h4
`define BSC_BTSS_OP 4'h7
`define BSC_CLEAR_FILE_REGISTER_OP_OP 7'h03
`define BSC_BIT_LO 7
`define BSC_BIT_W 3
`define BSC_ZERO_BIT 2
`define BSC_CLR_VAL 8'h00
`endif

// file: bsc_pkg.sv
// Types for the bit-test, call and clear-file execution block.
package bsc_pkg;
  typedef enum logic [1:0] {QPH1, QPH2, QPH3, QPH4} bsc_phase_t;
  typedef enum logic [1:0] {OP_NONE, OP_BTSS, OP_CALL, OP_CLEAR_FILE_REGISTER_OP} bsc_op_t;
endpackage : bsc_pkg

// file: bsc_dec_if.sv
// Interface carrying decoded instruction fields to the execution logic.
`timescale 1ns/100ps
`default_nettype none
interface bsc_dec_if;
  bsc_pkg::bsc_op_t op;
  logic [6:0] fileAddr;
  logic [2:0] bitSel;
  logic [10:0] literal;
  modport dec (output op, fileAddr, bitSel, literal);
  modport exe (input op, fileAddr, bitSel, literal);
endinterface : bsc_dec_if
`default_nettype wire

// file: bsc_decoder.sv
// Combinational decoder for the three supported instruction words.
`timescale 1ns/100ps
`default_nettype none
`include "bsc_defs.svh"
module bsc_decoder (
  // Instruction word.
  input wire logic [13:0] instr,
  // Decoded fields.
  bsc_dec_if.dec dec
);
  wire isCall = (instr[13:11] == `BSC_CALL_OP); // RL4
  wire isBtss = (instr[13:10] == `BSC_BTSS_OP);
  wire isClrf = (instr[13:7] == `BSC_CLEAR_FILE_REGISTER_OP_OP);
  // Opcode classes never overlap, so priority order is immaterial.
  assign dec.op = isCall ? bsc_pkg::OP_CALL :
                  isBtss ? bsc_pkg::OP_BTSS :
                  isClrf ? bsc_pkg::OP_CLEAR_FILE_REGISTER_OP : bsc_pkg::OP_NONE;
  assign dec.fileAddr = instr[6:0];
  assign dec.bitSel = instr[`BSC_BIT_LO +: `BSC_BIT_W];
  assign dec.literal = instr[10:0]; // RL4
endmodule : bsc_decoder
`default_nettype wire

// file: bsc_exec.sv
// Execution block for bit-test-skip, call and clear-file instructions.
`timescale 1ns/100ps
`default_nettype none
`include "bsc_defs.svh"
module bsc_exec (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Fetch side.
  input wire logic [13:0] instrWord,
  input wire logic [12:0] pcCur,
  input wire logic [7:0] pcHighLatch,
  // File register read data.
  input wire logic [7:0] fileRdData,
  // Phase and control outputs.
  output logic [1:0] qPhase,
  output logic fileRdEn,
  output logic [6:0] fileAddr,
  output logic fileWrEn,
  output logic [7:0] fileWrData,
  output logic zeroSet,
  output logic pcLoad,
  output logic [12:0] pcNext,
  output logic stackPush,
  output logic [12:0] stackData,
  output logic flushFetch,
  output logic instrDone
);
  // The decoder only classifies the fetched word; all timing lives here.
  bsc_dec_if decBus ();
  bsc_decoder u_dec (.instr(instrWord), .dec(decBus));

  bsc_pkg::bsc_phase_t phase_ff, nxt_phase;
  logic secondCyc_ff;
  logic bitHit_ff;
  logic [1:0] opLatch_ff;
  logic [6:0] fAddr_ff;
  logic [2:0] bSel_ff;
  logic [10:0] lit_ff;
  logic fileRdEn_ff, fileWrEn_ff, zeroSet_ff, pcLoad_ff, push_ff;
  logic flush_ff, done_ff;
  logic [12:0] pcNext_ff, stackData_ff;
  // Clear value is registered too, so that every port leaves a flop.
  logic [7:0] wrData_ff;

  // Phase advances Q1 to Q4 every clock and wraps.
  assign nxt_phase = bsc_pkg::bsc_phase_t'(phase_ff + 2'h1);

  // Decoded operation of the latched word; second cycles act as no-ops.
  wire bsc_pkg::bsc_op_t curOp = bsc_pkg::bsc_op_t'(opLatch_ff);
  wire activeCyc = ~secondCyc_ff;
  wire isBtss = activeCyc && (curOp == bsc_pkg::OP_BTSS);
  wire isCall = activeCyc && (curOp == bsc_pkg::OP_CALL);
  wire isClrf = activeCyc && (curOp == bsc_pkg::OP_CLEAR_FILE_REGISTER_OP);
  wire tested = fileRdData[bSel_ff];
  wire [12:0] retAddr = 13'(pcCur + 13'h0001); // RL5
  wire [12:0] callTgt = {pcHighLatch[`BSC_LATCH_LO +: 2], lit_ff}; // RL6
  wire atQ1 = (phase_ff == bsc_pkg::QPH1);
  wire atQ2 = (phase_ff == bsc_pkg::QPH2);
  wire atQ3 = (phase_ff == bsc_pkg::QPH3);
  wire atQ4 = (phase_ff == bsc_pkg::QPH4);
  // At Q3 the skip choice must use the bit being read right now, since
  // bitHit_ff only takes it on that same edge; Q4 then uses bitHit_ff.
  wire skipNow = isBtss & tested; // RL2
  wire noSkip = isBtss & ~tested; // RL1
  wire endsEarly = isCall | skipNow;
  // Only instructions that really ran report completion; the no-op
  // cycle and unknown words stay silent.
  wire oneCycleDone = noSkip | isClrf;
  wire needSecond = isCall | (isBtss & bitHit_ff);
  // Limitation: an unrecognised word is simply ignored; it neither
  // reads nor writes a file register and raises no strobe.

  // Strobe launch conditions; each shows one phase after it is seen.
  wire rdGo = atQ1 & (isBtss | isClrf); // RL3
  wire retGo = atQ1 & isCall; // RL5
  wire pushGo = atQ2 & isCall; // RL5
  wire tgtGo = atQ2 & isCall; // RL4 RL6
  wire clearGo = atQ3 & isClrf; // RL8
  wire loadGo = atQ3 & isCall; // RL4 RL6
  wire flushGo = atQ3 & endsEarly; // RL1 RL2 RL7
  wire doneGo = atQ3 & oneCycleDone; // RL1

  // Phase counter and instruction latch at Q4 of every cycle.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      phase_ff <= bsc_pkg::QPH1;
      opLatch_ff <= 2'h0;
      fAddr_ff <= 7'h00;
      bSel_ff <= 3'h0;
      lit_ff <= 11'h000;
    end
    else
    begin
      phase_ff <= nxt_phase;
      if (atQ4)
      begin
        opLatch_ff <= decBus.op; // RL3
        fAddr_ff <= decBus.fileAddr;
        bSel_ff <= decBus.bitSel;
        lit_ff <= decBus.literal; // RL4
      end
    end
  end

  // Bit sampled in Q3; skip or call makes the next cycle a no-op.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      bitHit_ff <= 1'b0;
      secondCyc_ff <= 1'b0;
    end
    else
    begin
      if (atQ3 && isBtss)
        bitHit_ff <= tested; // RL3
      else if (atQ4)
        bitHit_ff <= 1'b0;
      if (atQ4)
        secondCyc_ff <= needSecond; // RL2 RL7
    end
  end

  // File read strobe for Q2; bit-test never writes, so this is its only
  // file access.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      fileRdEn_ff <= 1'b0;
    else
      fileRdEn_ff <= rdGo; // RL3
  end

  // Clear-file write and zero flag go out together in Q4 and touch no
  // other status bit.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      fileWrEn_ff <= 1'b0;
      zeroSet_ff <= 1'b0;
      wrData_ff <= `BSC_CLR_VAL;
    end
    else
    begin
      fileWrEn_ff <= clearGo; // RL8
      zeroSet_ff <= clearGo; // RL8
      if (clearGo)
        wrData_ff <= `BSC_CLR_VAL; // RL8
    end
  end

  // Return address is captured in Q1 and pushed in Q3, one phase ahead
  // of the counter load, so the stack never sees the new target.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      push_ff <= 1'b0;
      stackData_ff <= 13'h0000;
    end
    else
    begin
      push_ff <= pushGo; // RL5
      if (retGo)
        stackData_ff <= retAddr; // RL5
    end
  end

  // Target is built in Q2 and loaded in Q4; it holds until the next call.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pcLoad_ff <= 1'b0;
      pcNext_ff <= 13'h0000;
    end
    else
    begin
      pcLoad_ff <= loadGo; // RL4 RL6
      if (tgtGo)
        pcNext_ff <= callTgt; // RL4 RL6
    end
  end

  // Discard the prefetched word when skipping or calling, so that the
  // following cycle runs as a no-op.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      flush_ff <= 1'b0;
    else
      flush_ff <= flushGo; // RL1 RL2 RL7
  end

  // Completion is reported only by instructions that really ran in one
  // cycle; a no-op second cycle or an unknown word stays silent.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      done_ff <= 1'b0;
    else
      done_ff <= doneGo; // RL1
  end

  // Ports are straight copies of the flops above.
  assign qPhase = phase_ff;
  assign fileRdEn = fileRdEn_ff;
  assign fileAddr = fAddr_ff;
  assign fileWrEn = fileWrEn_ff;
  assign fileWrData = wrData_ff; // RL8
  assign zeroSet = zeroSet_ff;
  assign pcLoad = pcLoad_ff;
  assign pcNext = pcNext_ff;
  assign stackPush = push_ff;
  assign stackData = stackData_ff;
  assign flushFetch = flush_ff;
  assign instrDone = done_ff;
endmodule : bsc_exec
`default_nettype wire

// file: bsc_exec_props.sv
// Checker for the execution block's phases and strobes.
`timescale 1ns/100ps
`default_nettype none
module bsc_exec_props (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Watched outputs.
  input wire logic [1:0] qPhase,
  input wire logic fileRdEn,
  input wire logic fileWrEn,
  input wire logic [7:0] fileWrData,
  input wire logic zeroSet,
  input wire logic pcLoad,
  input wire logic stackPush,
  input wire logic flushFetch,
  input wire logic instrDone
);
  // One clock domain, so checks share clocking and pause in reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_phase_steps: assert property ($past(rst_b, 2) |->
    qPhase == $past(qPhase) + 2'h1) else $error("phase skipped");
  a_read_in_q2: assert property (fileRdEn |-> qPhase == 2'h1)
    else $error("read strobe off Q2");
  a_clear_write: assert property (fileWrEn |-> qPhase == 2'h3 && zeroSet
    && fileWrData == 8'h00 && !flushFetch) else $error("bad clear");
  a_push_then_load: assert property (stackPush |-> qPhase == 2'h2
    ##1 pcLoad && flushFetch) else $error("push not followed by load");
  a_load_after_push: assert property (pcLoad |-> $past(stackPush))
    else $error("load without push");
  a_call_idle: assert property (pcLoad |=> (!stackPush && !pcLoad
    && !fileRdEn && !instrDone)[*4]) else $error("call cycle busy");
  a_skip_idle: assert property (flushFetch && !pcLoad |=> (!fileRdEn
    && !fileWrEn && !instrDone)[*4]) else $error("skip cycle busy");
  a_done_no_skip: assert property (instrDone |-> qPhase == 2'h3
    && !flushFetch) else $error("bad completion");
  a_zero_with_write: assert property (zeroSet |-> fileWrEn)
    else $error("zero flag without clear write");
endmodule : bsc_exec_props
bind bsc_exec bsc_exec_props u_props (.ref_clk, .rst_b, .qPhase, .fileRdEn,
  .fileWrEn, .fileWrData, .zeroSet, .pcLoad, .stackPush, .flushFetch,
  .instrDone);
`default_nettype wire

// file: bit_skip_call_clear_exec_tb.sv
// Testbench for the bit-test, call and clear-file block.
`timescale 1ns/100ps
`default_nettype none
module bit_skip_call_clear_exec_tb;
  logic ref_clk, rst_b, fileRdEn, fileWrEn, zeroSet, pcLoad, stackPush;
  logic flushFetch, instrDone;
  logic [1:0] qPhase;
  logic [6:0] fileAddr, addrSeen;
  logic [7:0] zSeen, wrSeen;
  logic [7:0] pcHighLatch, fileRdData, fileWrData;
  logic [12:0] pcCur, pcNext, stackData;
  logic [13:0] instrWord;
  logic [47:0] seen;
  int n_errors, n_compared, k;
  bsc_exec u_dut (.ref_clk, .rst_b, .instrWord, .pcCur, .pcHighLatch,
    .fileRdData, .qPhase, .fileRdEn, .fileAddr, .fileWrEn, .fileWrData,
    .zeroSet, .pcLoad, .pcNext, .stackPush, .stackData, .flushFetch,
    .instrDone);
  // Clock at 100 ns.
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: %h not %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk
  // Present a word in Q4, then log each strobe over the next two cycles.
  task run(input logic [13:0] w, input logic [7:0] d);
    for (k = 0; k < 20 && qPhase !== 2'h3; k++)
      @(negedge ref_clk);
    instrWord = w;
    fileRdData = d;
    for (k = 0; k < 8; k++)
    begin
      @(negedge ref_clk);
      instrWord = 14'h0000;
      if (k == 1)
        addrSeen = fileAddr;
      if (k == 3)
        wrSeen = fileWrData;
      zSeen[k] = zeroSet;
      {seen[40+k], seen[32+k], seen[24+k], seen[16+k], seen[8+k], seen[k]} =
        {instrDone, flushFetch, pcLoad, stackPush, fileWrEn, fileRdEn};
    end
  endtask : run
  task t_clear_skip;
    run(14'h01d5, 8'h5a);
    chk(seen, 48'h080000000802);
    chk({41'h0, addrSeen}, 48'h55);
    chk({40'h0, zSeen}, 48'h08);
    chk({40'h0, wrSeen}, 48'h00);
    run(14'h1f80, 8'h80);
    chk(seen, 48'h000800000002);
    chk({40'h0, zSeen}, 48'h00);
    run(14'h1c7f, 8'hfe);
    chk(seen, 48'h080000000002);
    chk({40'h0, zSeen}, 48'h00);
    $display("clear and skip test done");
  endtask : t_clear_skip
  // Back-to-back calls; the second wraps the return address.
  task t_call;
    pcCur = 13'h07ff;
    pcHighLatch = 8'h18;
    run(14'h25a5, 8'h00);
    chk(seen, 48'h000808040000);
    chk({22'h0, pcNext, stackData}, {22'h0, 13'h1da5, 13'h0800});
    pcCur = 13'h1fff;
    pcHighLatch = 8'he7;
    run(14'h27ff, 8'h00);
    chk(seen, 48'h000808040000);
    chk({40'h0, zSeen}, 48'h00);
    chk({22'h0, pcNext, stackData}, {22'h0, 13'h07ff, 13'h0000});
    $display("call test done");
  endtask : t_call
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Main sequence; inputs move on the falling edge.
  initial
  begin
    {rst_b, instrWord, pcCur, pcHighLatch, fileRdData} = '0;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    t_clear_skip;
    t_call;
    give_verdict;
  end
  // Hang guard at 1000 cycles, well past the 60 or so cycles the tests need.
  initial
  begin
    #100000;
    n_errors++;
    give_verdict;
  end
endmodule : bit_skip_call_clear_exec_tb
`default_nettype wire
